//--- rtl/lpddr2_power_down_clock_stop.sv
/*
 * Device-side power state tracker: power-down, deep power-down, clock stop
 * and NOP decode at each memory-clock rising edge.
 * Assumes the controller keeps its own CKE-low spacing after each command.
 */
// What this block does
// - CKE falling with CS low, CA0 high, CA1 high, CA2 low enters deep power-down.
// - CKE high leaves deep power-down; full initialization required before use.
// - After clock restart with CKE high, ready only after 2 tCK plus tXP.
// - NOP only when CKE is unchanged; CS high or CA0..CA2 all high.
// - NOP registers nothing and does not end an operation in progress.
// - CKE falling with CS high, after CKE high, enters power-down.
`default_nettype none
module lpddr2_power_down_clock_stop (
   // Core clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Memory pins
   input wire logic ck_pin,
   input wire lpddr2_pd_pkg::pins_t pins_in,
   // From the device's initialization logic
   input wire logic init_done,
   // Power state
   output logic ready_q,
   output logic power_down_q,
   output logic deep_power_down_q,
   output logic init_required_q,
   output logic clock_stopped_q,
   // Decoded commands
   output logic cmd_q,
   output logic [2:0] cmd_ca_q,
   output logic nop_q
);

   typedef enum logic [2:0] {
      st_active, st_pd, st_deep, st_init, st_xp, st_restart
   } state_t;

   localparam int XP_MAX = 4;

   logic [1:0] rst_sync_q;
   logic rst_sync_n;
   lpddr2_pd_pkg::pins_t pins;
   logic ck_rise;
   state_t state_q;
   logic cke_prev_q;
   logic [3:0] cnt_q;
   logic [1:0] edges_q;
   logic [7:0] idle_q;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= lpddr2_pd_pkg::RESET_SYNC_INIT;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_q[1];

   lpddr2_pin_sampler u_sampler (
      .clock(clock),
      .rst_n(rst_sync_n),
      .ck_pin(ck_pin),
      .pins_in(pins_in),
      .pins_sync(pins),
      .ck_rise(ck_rise)
   );

   function automatic logic is_nop(input lpddr2_pd_pkg::pins_t p);
      is_nop = p.cs_n || (p.ca == lpddr2_pd_pkg::CA_NOP);
   endfunction : is_nop

   wire cke_fall = ck_rise && cke_prev_q && !pins.cke;
   wire cke_rise = ck_rise && !cke_prev_q && pins.cke;
   wire deep_entry = cke_fall && !pins.cs_n && (pins.ca == lpddr2_pd_pkg::CA_DEEP_POWER_DOWN);
   wire pd_entry = cke_fall && pins.cs_n;
   wire stop_seen = (idle_q == lpddr2_pd_pkg::CK_STOP_CYCLES);

   // CKE as registered at the previous memory-clock edge.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cke_prev_q <= 1'b0;
      end else if (ck_rise) begin
         cke_prev_q <= pins.cke;
      end
   end

   // Core cycles since the last memory-clock edge, used to spot a stopped clock.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         idle_q <= 8'h00;
      end else if (ck_rise) begin
         idle_q <= 8'h00;
      end else if (!stop_seen) begin
         idle_q <= idle_q + 8'h01;
      end
   end

   // Power state sequencing.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= st_init;
         cnt_q <= 4'h0;
         edges_q <= 2'h0;
      end else begin
         unique case (state_q)
            st_active: begin
               if (deep_entry) begin
                  state_q <= st_deep;
               end else if (pd_entry) begin
                  state_q <= st_pd;
               end else if (stop_seen && cke_prev_q) begin
                  state_q <= st_restart;
                  edges_q <= 2'h0;
               end
            end
            st_pd: begin
               if (cke_rise) begin
                  state_q <= st_xp;
                  cnt_q <= lpddr2_pd_pkg::XP_CYCLES;
               end
            end
            st_deep: begin
               if (cke_rise) begin
                  state_q <= st_init;
               end
            end
            st_init: begin
               if (init_done) begin
                  state_q <= st_active;
               end
            end
            st_restart: begin
               // Count two clean edges before the exit latency starts.
               if (ck_rise) begin
                  if (edges_q == lpddr2_pd_pkg::RESTART_CK_EDGES - 2'h1) begin
                     state_q <= st_xp;
                     cnt_q <= lpddr2_pd_pkg::XP_CYCLES;
                  end else begin
                     edges_q <= edges_q + 2'h1;
                  end
               end
            end
            st_xp: begin
               if (cnt_q <= 4'h1) begin
                  state_q <= st_active;
                  cnt_q <= 4'h0;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
         endcase
      end
   end

   // Status outputs, one cycle behind the state; clock_stopped_q is one cycle behind the stop detect.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ready_q <= 1'b0;
         power_down_q <= 1'b0;
         deep_power_down_q <= 1'b0;
         init_required_q <= 1'b1;
         clock_stopped_q <= 1'b0;
      end else begin
         ready_q <= (state_q == st_active);
         power_down_q <= (state_q == st_pd);
         deep_power_down_q <= (state_q == st_deep);
         init_required_q <= (state_q == st_deep) || (state_q == st_init);
         clock_stopped_q <= stop_seen;
      end
   end

   // Command decode; a NOP produces no command and leaves running work alone.
   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cmd_q <= 1'b0;
         cmd_ca_q <= 3'h0;
         nop_q <= 1'b0;
      end else begin
         cmd_q <= 1'b0;
         nop_q <= 1'b0;
         if (ck_rise && (cke_prev_q == pins.cke) && pins.cke && state_q == st_active) begin
            if (is_nop(pins)) begin
               nop_q <= 1'b1;
            end else begin
               cmd_q <= 1'b1;
               cmd_ca_q <= pins.ca;
            end
         end
      end
   end

   property p_deep_entry;
      @(posedge clock) disable iff (!rst_sync_n)
      (state_q == st_active && deep_entry) |=> ##1 deep_power_down_q;
   endproperty
   a_deep_entry: assert property (p_deep_entry) else $error("deep power-down not entered");

   property p_pd_entry;
      @(posedge clock) disable iff (!rst_sync_n)
      (state_q == st_active && pd_entry) |=> ##1 (power_down_q && !deep_power_down_q);
   endproperty
   a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

   property p_deep_exit;
      @(posedge clock) disable iff (!rst_sync_n)
      (state_q == st_deep && cke_rise) |=> ##1 (init_required_q && !ready_q);
   endproperty
   a_deep_exit: assert property (p_deep_exit) else $error("exit did not demand init");

   property p_init_blocks_ready;
      @(posedge clock) disable iff (!rst_sync_n)
      init_required_q |-> !ready_q;
   endproperty
   a_init_blocks_ready: assert property (p_init_blocks_ready)
      else $error("ready while uninit");

   // Only a sampled init_done may open the way from the init state to ready.
   property p_init_gates_ready;
      @(posedge clock) disable iff (!rst_sync_n)
      (init_required_q && !$past(init_done)) |=> !ready_q;
   endproperty
   a_init_gates_ready: assert property (p_init_gates_ready)
      else $error("ready without init done");

   property p_nop_only_steady;
      @(posedge clock) disable iff (!rst_sync_n)
      (ck_rise && cke_prev_q != pins.cke) |=> !nop_q && !cmd_q;
   endproperty
   a_nop_only_steady: assert property (p_nop_only_steady) else $error("nop on cke change");

   property p_nop_no_cmd;
      @(posedge clock) disable iff (!rst_sync_n)
      (ck_rise && state_q == st_active && pins.cke && cke_prev_q && is_nop(pins))
         |=> nop_q && !cmd_q && $stable(cmd_ca_q);
   endproperty
   a_nop_no_cmd: assert property (p_nop_no_cmd) else $error("nop registered a command");

   property p_restart_not_ready;
      @(posedge clock) disable iff (!rst_sync_n)
      (state_q == st_restart) |=> ##1 !ready_q;
   endproperty
   a_restart_not_ready: assert property (p_restart_not_ready)
      else $error("ready in restart");

   property p_xp_bounded;
      @(posedge clock) disable iff (!rst_sync_n)
      $rose(state_q == st_xp) |-> !ready_q ##[1:XP_MAX] (state_q == st_active);
   endproperty
   a_xp_bounded: assert property (p_xp_bounded) else $error("exit latency wrong");

endmodule : lpddr2_power_down_clock_stop
`default_nettype wire

//--- rtl/lpddr2_pd_pkg.sv
/*
 * Shared types and constants for the power-down and clock-stop tracker.
 * Assumes a 40 MHz core clock and a memory clock that is much slower than it.
 */
`default_nettype none
package lpddr2_pd_pkg;

   // One sample of the command pins, taken at a memory-clock rising edge.
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic [2:0] ca;
   } pins_t;

   localparam int CLOCK_PERIOD_PS = 25000;
   localparam int T_XP_PS = 7500;
   // Least time, so the count rounds up.
   localparam int XP_CYCLES_INT = (T_XP_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
   localparam logic [3:0] XP_CYCLES = 4'(XP_CYCLES_INT < 1 ? 1 : XP_CYCLES_INT);
   localparam logic [1:0] RESTART_CK_EDGES = 2'h2;
   localparam logic [7:0] CK_STOP_CYCLES = 8'h20;
   localparam logic [2:0] CA_DEEP_POWER_DOWN = 3'h3;
   localparam logic [2:0] CA_NOP = 3'h7;
   localparam logic [1:0] RESET_SYNC_INIT = 2'h0;

endpackage : lpddr2_pd_pkg
`default_nettype wire

//--- rtl/lpddr2_pin_sampler.sv
/*
 * Brings the memory clock and command pins into the core clock domain and
 * flags each rising edge of the memory clock.
 * Assumes the core clock samples the memory clock several times per period.
 */
`default_nettype none
module lpddr2_pin_sampler (
   // Core clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pins from outside
   input wire logic ck_pin,
   input wire lpddr2_pd_pkg::pins_t pins_in,
   // Synchronised view
   output lpddr2_pd_pkg::pins_t pins_sync,
   output logic ck_rise
);

   lpddr2_pd_pkg::pins_t pins_meta_q;
   lpddr2_pd_pkg::pins_t pins_sync_q;
   logic ck_meta_q;
   logic ck_sync_q;
   logic ck_last_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pins_meta_q <= '{cke: 1'b0, cs_n: 1'b1, ca: 3'h0};
         pins_sync_q <= '{cke: 1'b0, cs_n: 1'b1, ca: 3'h0};
         ck_meta_q <= 1'b0;
         ck_sync_q <= 1'b0;
         ck_last_q <= 1'b0;
      end else begin
         pins_meta_q <= pins_in;
         pins_sync_q <= pins_meta_q;
         ck_meta_q <= ck_pin;
         ck_sync_q <= ck_meta_q;
         ck_last_q <= ck_sync_q;
      end
   end

   // Pins travel with the clock so their sample lines up with the edge flag.
   assign pins_sync = pins_sync_q;
   assign ck_rise = ck_sync_q && !ck_last_q;

endmodule : lpddr2_pin_sampler
`default_nettype wire

//--- test/lpddr2_ctrl_model.sv
/*
 * Controller model: drives the memory clock and the command pins.
 * Assumes the bench core clock as time base; pins change at its falling edge.
 */
`default_nettype none
module lpddr2_ctrl_model (
   // Time base
   input wire logic clock,
   // Pins to the device
   output logic ck_pin,
   output lpddr2_pd_pkg::pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;

   // Command timing assumed for the controller; plain values, not tied to a speed grade.
   parameter int READ_LAT = 3;
   parameter int WRITE_LAT = 1;
   parameter int BURST_LEN = 4;
   parameter int SKEW_PS = 5500;
   parameter int RECOVERY_PS = 15000;
   parameter int SETTLE_PS = 10000;
   localparam int CK_PS = 200000;

   // Times round up to whole memory clocks, so CKE can only fall late, never early.
   function automatic int to_cycles(input int ps);
      to_cycles = (ps + CK_PS - 1) / CK_PS;
   endfunction : to_cycles

   // Longest wait that any earlier command asks for before CKE may be registered low.
   function automatic int cke_low_gap(input int rl, input int wl, input int bl);
      int rd;
      int wr;
      rd = rl + to_cycles(SKEW_PS) + bl / 2 + 1;
      wr = wl + 1 + bl / 2 + to_cycles(RECOVERY_PS) + 1;
      cke_low_gap = (rd > wr) ? rd : wr;
      if (to_cycles(SETTLE_PS) > cke_low_gap) begin
         cke_low_gap = to_cycles(SETTLE_PS);
      end
   endfunction : cke_low_gap

   initial begin
      ck_pin = 1'b0;
      pins = '{cke: 1'b1, cs_n: 1'b1, ca: 3'h7};
   end

   // One 200 ns memory clock, pins set up half a period before the rise.
   task automatic edge_out(input logic cke, input logic cs_n, input logic [2:0] ca);
      begin
         pins.cke = cke;
         pins.cs_n = cs_n;
         // Deselected CA lines toggle so a stale value is never trusted.
         pins.ca = cs_n ? ~pins.ca : ca;
         repeat (4) @(negedge clock);
         ck_pin = 1'b1;
         repeat (4) @(negedge clock);
         ck_pin = 1'b0;
      end
   endtask : edge_out

   // Clock held low with CS high while stopped.
   task automatic stop_ck(input int n);
      begin
         pins.cs_n = 1'b1;
         repeat (n) @(negedge clock);
      end
   endtask : stop_ck

   // NOPs with CKE high until all earlier work is done and the banks are idle.
   task automatic drain;
      begin
         repeat (cke_low_gap(READ_LAT, WRITE_LAT, BURST_LEN)) begin
            edge_out(1'b1, 1'b1, 3'h7);
         end
      end
   endtask : drain
endmodule : lpddr2_ctrl_model
`default_nettype wire

//--- test/lpddr2_power_down_clock_stop_tb.sv
/*
 * Self-checking bench for the power state tracker.
 * Assumes a 40 MHz core clock and the controller model as the pin driver.
 */
`default_nettype none
module lpddr2_power_down_clock_stop_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock;
   logic reset_n;
   logic init_done;
   logic ck_pin;
   lpddr2_pd_pkg::pins_t pins;
   logic ready_q, power_down_q, deep_power_down_q, init_required_q, clock_stopped_q;
   logic cmd_q, nop_q;
   logic [2:0] cmd_ca_q;
   int err_count = 0;
   int samples_checked = 0;
   int nop_seen = 0;
   int cmd_seen = 0;

   lpddr2_ctrl_model i_ctrl (.clock(clock), .ck_pin(ck_pin), .pins(pins));

   lpddr2_power_down_clock_stop i_dut (
      .clock(clock), .reset_n(reset_n), .ck_pin(ck_pin), .pins_in(pins),
      .init_done(init_done), .ready_q(ready_q), .power_down_q(power_down_q),
      .deep_power_down_q(deep_power_down_q), .init_required_q(init_required_q),
      .clock_stopped_q(clock_stopped_q), .cmd_q(cmd_q), .cmd_ca_q(cmd_ca_q),
      .nop_q(nop_q));

   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // One-cycle pulses are counted so no check depends on catching one cycle.
   always @(posedge clock) begin
      if (nop_q === 1'b1) nop_seen++;
      if (cmd_q === 1'b1) cmd_seen++;
   end

   task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
      begin
         samples_checked++;
         if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
         end
      end
   endtask : chk

   task automatic settle;
      begin
         repeat (4) @(negedge clock);
      end
   endtask : settle

   task automatic pulse_init;
      begin
         init_done = 1'b1;
         @(negedge clock);
         init_done = 1'b0;
         repeat (2) @(negedge clock);
      end
   endtask : pulse_init

   task automatic t_reset;
      begin
         repeat (5) @(negedge clock);
         reset_n = 1'b1;
         chk("init_required", 3'h1, {2'h0, init_required_q});
         chk("ready", 3'h0, {2'h0, ready_q});
         repeat (8) @(negedge clock);
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         pulse_init();
         chk("ready", 3'h1, {2'h0, ready_q});
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         $display("test reset done");
      end
   endtask : t_reset

   task automatic t_nop;
      begin
         nop_seen = 0;
         cmd_seen = 0;
         i_ctrl.edge_out(1'b1, 1'b1, 3'h0);
         i_ctrl.edge_out(1'b1, 1'b0, 3'h7);
         i_ctrl.edge_out(1'b1, 1'b0, 3'h5);
         i_ctrl.edge_out(1'b1, 1'b1, 3'h2);
         settle();
         chk("nop count", 3'h3, 3'(nop_seen));
         chk("cmd count", 3'h1, 3'(cmd_seen));
         chk("cmd_ca", 3'h5, cmd_ca_q);
         $display("test nop done");
      end
   endtask : t_nop

   task automatic t_power_down;
      begin
         i_ctrl.drain();
         cmd_seen = 0;
         i_ctrl.edge_out(1'b0, 1'b1, 3'h7);
         i_ctrl.edge_out(1'b0, 1'b0, 3'h5);
         settle();
         chk("power_down", 3'h1, {2'h0, power_down_q});
         chk("ready", 3'h0, {2'h0, ready_q});
         chk("cmd count", 3'h0, 3'(cmd_seen));
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         settle();
         chk("power_down", 3'h0, {2'h0, power_down_q});
         chk("ready", 3'h1, {2'h0, ready_q});
         $display("test power down done");
      end
   endtask : t_power_down

   task automatic t_deep;
      begin
         i_ctrl.drain();
         i_ctrl.edge_out(1'b0, 1'b0, lpddr2_pd_pkg::CA_DEEP_POWER_DOWN);
         i_ctrl.edge_out(1'b0, 1'b1, 3'h7);
         i_ctrl.edge_out(1'b0, 1'b1, 3'h7);
         settle();
         chk("deep_power_down", 3'h1, {2'h0, deep_power_down_q});
         chk("power_down", 3'h0, {2'h0, power_down_q});
         chk("init_required", 3'h1, {2'h0, init_required_q});
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         settle();
         chk("deep_power_down", 3'h0, {2'h0, deep_power_down_q});
         chk("ready", 3'h0, {2'h0, ready_q});
         pulse_init();
         chk("ready", 3'h1, {2'h0, ready_q});
         chk("init_required", 3'h0, {2'h0, init_required_q});
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         $display("test deep power down done");
      end
   endtask : t_deep

   task automatic t_clock_stop;
      begin
         i_ctrl.stop_ck(40);
         chk("clock_stopped", 3'h1, {2'h0, clock_stopped_q});
         chk("ready", 3'h0, {2'h0, ready_q});
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         settle();
         chk("ready", 3'h0, {2'h0, ready_q});
         i_ctrl.edge_out(1'b1, 1'b1, 3'h7);
         settle();
         chk("ready", 3'h1, {2'h0, ready_q});
         chk("clock_stopped", 3'h0, {2'h0, clock_stopped_q});
         // A latency update right after the restart must be taken as a command.
         cmd_seen = 0;
         i_ctrl.edge_out(1'b1, 1'b0, 3'h0);
         settle();
         chk("cmd count", 3'h1, 3'(cmd_seen));
         chk("cmd_ca", 3'h0, cmd_ca_q);
         $display("test clock stop done");
      end
   endtask : t_clock_stop

   task automatic final_report;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
         end else begin
            $display("Regression broken");
         end
         $finish;
      end
   endtask : final_report

   initial begin
      reset_n = 1'b0;
      init_done = 1'b0;
      t_reset();
      t_nop();
      t_power_down();
      t_deep();
      t_clock_stop();
      final_report();
   end

   // The tests need under 1000 core cycles; a hang is cut off well after.
   initial begin
      repeat (5000) @(posedge clock);
      err_count++;
      final_report();
   end
endmodule : lpddr2_power_down_clock_stop_tb
`default_nettype wire
